/* File: asram_host.sv */
// host controller that drives an asynchronous 16-bit byte-lane static memory
`timescale 1ns/1ps
`default_nettype none
`include "asram_map.svh"
module asram_host
    import asram_pkg::*;
#(
    parameter int ADDR_W = `ASRAM_ADDR_W,
    parameter int DATA_W = `ASRAM_DATA_W,
    parameter int RD_CYC = `ASRAM_RD_CYC,
    parameter int WR_CYC = `ASRAM_WR_CYC,
    parameter int TURN_CYC = `ASRAM_TURN_CYC
) (
    // clocking
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // user request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic [1:0] req_byte_en,
    // user answer
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    // memory pins
    output logic [ADDR_W-1:0] word_address,
    output logic select_low_active,
    output logic select_high_active,
    output logic output_enable_n,
    output logic write_enable_n,
    output logic lower_byte_enable_n,
    output logic upper_byte_enable_n,
    output logic [DATA_W-1:0] data_bus_out,
    output logic data_bus_oe_n,
    input wire logic [DATA_W-1:0] data_bus_in
);
    // ************************************
    // state
    // ************************************
    asram_state_e state_r;
    logic [7:0] cnt_r;
    logic [1:0] be_r;
    logic [DATA_W-1:0] rd_sync;
    logic rsp_r;
    logic [DATA_W-1:0] rdata_r;

    asram_sync #(.W(DATA_W)) u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .d(data_bus_in),
        .q(rd_sync)
    );

    // ready only when idle so a request never lands mid-cycle
    assign req_ready = (state_r == ASRAM_IDLE);
    assign rsp_valid = rsp_r;
    assign rsp_rdata = rdata_r;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_r <= ASRAM_IDLE;
            cnt_r <= 8'h00;
        end
        else if (clk_en)
        begin
            unique case (state_r)
                ASRAM_IDLE:
                begin
                    if (req_valid)
                    begin
                        state_r <= req_write ? ASRAM_WR : ASRAM_RD;
                        // two extra cycles cover the read synchroniser
                        cnt_r <= req_write ? 8'(WR_CYC) : 8'(RD_CYC + 2);
                    end
                end
                ASRAM_RD:
                begin
                    cnt_r <= cnt_r - 8'h01;
                    if (cnt_r == 8'h01)
                    begin
                        state_r <= ASRAM_TURN;
                        cnt_r <= 8'(TURN_CYC);
                    end
                end
                ASRAM_WR:
                begin
                    cnt_r <= cnt_r - 8'h01;
                    if (cnt_r == 8'h01)
                        state_r <= ASRAM_WR_END;
                end
                ASRAM_WR_END:
                begin
                    state_r <= ASRAM_IDLE;
                end
                ASRAM_TURN:
                begin
                    cnt_r <= cnt_r - 8'h01;
                    if (cnt_r <= 8'h01)
                        state_r <= ASRAM_IDLE;
                end
            endcase
        end
    end

    // ************************************
    // memory pins
    // ************************************
    // address and lanes latch at acceptance, on the same edge that asserts the selects
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            word_address <= '0;
            be_r <= 2'h0;
            data_bus_out <= '0;
        end
        else if (clk_en && state_r == ASRAM_IDLE && req_valid)
        begin
            word_address <= req_addr;
            be_r <= req_byte_en;
            data_bus_out <= req_wdata;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            select_low_active <= 1'b1;
            select_high_active <= 1'b0;
            output_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            lower_byte_enable_n <= 1'b1;
            upper_byte_enable_n <= 1'b1;
            data_bus_oe_n <= 1'b1;
        end
        else if (clk_en)
        begin
            // write enable held high in reads; write ends on its rise
            write_enable_n <= !(state_r == ASRAM_IDLE && req_valid && req_write)
                && !(state_r == ASRAM_WR && cnt_r != 8'h01);
            // selects and lanes stay up one cycle past write enable rise
            select_low_active <= !(state_r == ASRAM_IDLE && req_valid)
                && !(state_r == ASRAM_RD) && !(state_r == ASRAM_WR);
            select_high_active <= (state_r == ASRAM_IDLE && req_valid)
                || state_r == ASRAM_RD || state_r == ASRAM_WR;
            output_enable_n <= !(state_r == ASRAM_IDLE && req_valid && !req_write)
                && !(state_r == ASRAM_RD && cnt_r != 8'h01);
            lower_byte_enable_n <= (state_r == ASRAM_IDLE && req_valid) ? !req_byte_en[0]
                : (state_r == ASRAM_RD || state_r == ASRAM_WR) ? !be_r[0] : 1'b1;
            upper_byte_enable_n <= (state_r == ASRAM_IDLE && req_valid) ? !req_byte_en[1]
                : (state_r == ASRAM_RD || state_r == ASRAM_WR) ? !be_r[1] : 1'b1;
            // data driven until the cycle after write enable rises: hold
            data_bus_oe_n <= !(state_r == ASRAM_IDLE && req_valid && req_write)
                && !(state_r == ASRAM_WR);
        end
    end

    // ************************************
    // read answer
    // ************************************
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            rsp_r <= 1'b0;
            rdata_r <= '0;
        end
        else if (clk_en)
        begin
            rsp_r <= (state_r == ASRAM_RD && cnt_r == 8'h01) || state_r == ASRAM_WR_END;
            if (state_r == ASRAM_RD && cnt_r == 8'h01)
                // floated lanes read as zero
                rdata_r <= rd_sync & {{8{be_r[1]}}, {8{be_r[0]}}};
        end
    end

    // ************************************
    // checks
    // ************************************
    property p_we_high_in_read;
        @(posedge sys_clk) disable iff (reset)
        !output_enable_n |-> write_enable_n;
    endproperty
    a_we_high_in_read: assert property (p_we_high_in_read) else $error("we low in read");

    property p_no_drive_while_oe;
        @(posedge sys_clk) disable iff (reset)
        !output_enable_n |-> data_bus_oe_n;
    endproperty
    a_no_drive_while_oe: assert property (p_no_drive_while_oe) else $error("bus fight");

    property p_we_qualified;
        @(posedge sys_clk) disable iff (reset)
        !write_enable_n |-> !select_low_active && select_high_active && !data_bus_oe_n
            && (!lower_byte_enable_n || !upper_byte_enable_n || be_r == 2'h0);
    endproperty
    a_we_qualified: assert property (p_we_qualified) else $error("write unqualified");

    sequence s_we_rise;
        $rose(write_enable_n) && clk_en;
    endsequence
    property p_data_hold;
        @(posedge sys_clk) disable iff (reset)
        s_we_rise |-> !data_bus_oe_n && !select_low_active && $stable(data_bus_out);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data hold lost");

    property p_addr_stable;
        @(posedge sys_clk) disable iff (reset)
        !select_low_active && !$rose(!select_low_active) |-> $stable(word_address);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("addr moved");

    property p_write_len;
        @(posedge sys_clk) disable iff (reset || !clk_en)
        // 45 ns pulse at a 10 ns clock needs five low cycles
        $fell(write_enable_n) |-> !write_enable_n [*5];
    endproperty
    a_write_len: assert property (p_write_len) else $error("write too short");

    property p_read_answer;
        @(posedge sys_clk) disable iff (reset || !clk_en)
        $fell(output_enable_n) |-> ##[1:20] rsp_valid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read no answer");

    property p_idle_float;
        @(posedge sys_clk) disable iff (reset)
        select_low_active |-> data_bus_oe_n && write_enable_n;
    endproperty
    a_idle_float: assert property (p_idle_float) else $error("driving deselected");
endmodule
`default_nettype wire

/* File: asram_map.svh */
// offsets-free constant map for the async memory host controller: widths and timing counts
`ifndef ASRAM_MAP_SVH
`define ASRAM_MAP_SVH
`define ASRAM_ADDR_W 19
`define ASRAM_DATA_W 16
`define ASRAM_CLK_PERIOD_NS 10
// read cycle time and write pulse width, slowest grade
`define ASRAM_T_RC_NS 55
`define ASRAM_T_PWE_NS 45
`define ASRAM_T_SD_NS 30
`define ASRAM_T_HZ_NS 20
`define ASRAM_RD_CYC ((`ASRAM_T_RC_NS + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS)
`define ASRAM_WR_CYC ((`ASRAM_T_PWE_NS + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS)
`define ASRAM_TURN_CYC ((`ASRAM_T_HZ_NS + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS)
`endif

/* File: asram_mem_model.sv */
// behavioural async 16-bit byte-lane static memory facing the host
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// memory model
// ****************************************
module asram_mem_model #(
    parameter int ACC_NS = 55
) (
    // strobes
    input wire logic [18:0] word_address,
    input wire logic select_low_active,
    input wire logic select_high_active,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic lower_byte_enable_n,
    input wire logic upper_byte_enable_n,
    // data
    input wire logic [15:0] data_bus,
    output logic [15:0] rd_data,
    output logic [1:0] lane_drive
);
    logic [15:0] mem [0:524287];
    logic sel;
    logic wr_act;
    logic rd_act;
    logic [15:0] wd;
    logic [1:0] wl;
    logic [18:0] wa;
    assign sel = !select_low_active && select_high_active;
    assign wr_act = sel && !write_enable_n
        && !(lower_byte_enable_n && upper_byte_enable_n);
    assign rd_act = sel && write_enable_n && !output_enable_n;
    assign lane_drive = {2{rd_act}} & ~{upper_byte_enable_n, lower_byte_enable_n};
    // slow answer on purpose: data follows address, no wait states
    assign #ACC_NS rd_data = mem[word_address];
    always @(*)
    begin
        if (wr_act)
        begin
            wd = data_bus;
            wl = ~{upper_byte_enable_n, lower_byte_enable_n};
            wa = word_address;
        end
    end
    // store at the end of the overlap, whichever qualifier ends it
    always @(negedge wr_act)
    begin
        if (wl[0]) mem[wa][7:0] = wd[7:0];
        if (wl[1]) mem[wa][15:8] = wd[15:8];
    end
endmodule
`default_nettype wire

/* File: asram_pkg.sv */
// types for the async memory host controller
package asram_pkg;
    typedef enum logic [2:0] {ASRAM_IDLE, ASRAM_RD, ASRAM_WR, ASRAM_WR_END, ASRAM_TURN} asram_state_e;
endpackage

/* File: asram_sync.sv */
// two-flop synchroniser for the read data bus
`timescale 1ns/1ps
`default_nettype none
module asram_sync #(
    parameter int W = 16
) (
    // clocking
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else if (clk_en)
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the async memory host controller
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench
// ****************************************
module testbench;
    logic sys_clk = 0;
    logic reset = 1;
    logic clk_en = 1;
    logic req_valid = 0;
    logic req_write = 0;
    logic [18:0] req_addr = 19'h00000;
    logic [15:0] req_wdata = 16'h0000;
    logic [1:0] req_byte_en = 2'h0;
    logic req_ready, rsp_valid, select_low_active, select_high_active;
    logic output_enable_n, write_enable_n, data_bus_oe_n;
    logic lower_byte_enable_n, upper_byte_enable_n;
    logic [15:0] rsp_rdata, data_bus_out, data_bus_in, mem_q, got;
    logic [15:0] float_r = 16'h5A3C;
    logic [15:0] exp_wd = 16'h0000;
    logic [18:0] word_address;
    logic [18:0] exp_addr = 19'h00000;
    logic [1:0] mem_drv;
    logic prev_sel = 1;
    logic prev_we = 1;
    int bad_count = 0;
    int n_checks = 0;
    // released lanes toggle every cycle so stale data never passes
    assign data_bus_in = !data_bus_oe_n ? data_bus_out :
        {mem_drv[1] ? mem_q[15:8] : float_r[15:8], mem_drv[0] ? mem_q[7:0] : float_r[7:0]};
    asram_host dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_byte_en(req_byte_en),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .word_address(word_address),
        .select_low_active(select_low_active), .select_high_active(select_high_active),
        .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
        .lower_byte_enable_n(lower_byte_enable_n), .upper_byte_enable_n(upper_byte_enable_n),
        .data_bus_out(data_bus_out), .data_bus_oe_n(data_bus_oe_n), .data_bus_in(data_bus_in));
    asram_mem_model mem (.word_address(word_address), .select_low_active(select_low_active),
        .select_high_active(select_high_active), .output_enable_n(output_enable_n),
        .write_enable_n(write_enable_n), .lower_byte_enable_n(lower_byte_enable_n),
        .upper_byte_enable_n(upper_byte_enable_n), .data_bus(data_bus_in),
        .rd_data(mem_q), .lane_drive(mem_drv));
    initial forever #5 sys_clk = ~sys_clk;
    task automatic check(input string what, input logic [18:0] e, input logic [18:0] s);
        n_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // one request, held until taken, then wait for its answer
    task automatic xfer(input logic wr, input logic [18:0] a, input logic [15:0] d,
        input logic [1:0] be, input int stall = 0);
        int i;
        exp_addr = a;
        exp_wd = d;
        req_valid <= 1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        req_byte_en <= be;
        for (i = 0; i < 30 && !(i > 0 && req_ready); i++) @(posedge sys_clk);
        if (i == 30)
        begin
            check("request taken in time", 19'h1, 19'h0);
            final_report();
        end
        req_valid <= 0;
        // clock enable low right after acceptance: pins must hold mid-cycle
        if (stall > 0)
        begin
            clk_en <= 0;
            repeat (stall) @(posedge sys_clk);
            check("we held while frozen", 19'(!wr), 19'(write_enable_n));
            check("addr held while frozen", a, word_address);
            clk_en <= 1;
        end
        for (i = 0; i < 30 && !(i > 0 && rsp_valid); i++) @(posedge sys_clk);
        if (i == 30)
        begin
            check("answer in time", 19'h1, 19'h0);
            final_report();
        end
        got = rsp_rdata;
    endtask
    task automatic rd(input logic [18:0] a, input logic [1:0] be, input logic [15:0] e);
        xfer(0, a, 16'h0000, be);
        check("read data", 19'(e), 19'(got));
    endtask
    // pin-level watchers on the controller's own strobes
    always @(posedge sys_clk)
    begin
        float_r <= ~float_r;
        if (!reset)
        begin
            if (!select_low_active && !output_enable_n)
                check("we in read", 19'h1, 19'(write_enable_n));
            if (prev_sel && !select_low_active)
                check("addr at select", exp_addr, word_address);
            if (!prev_we && write_enable_n)
            begin
                check("wdata at end", 19'(exp_wd), 19'(data_bus_out));
                check("bus driven at end", 19'h0, 19'(data_bus_oe_n));
                check("select at end", 19'h0, 19'(select_low_active));
            end
            prev_sel <= select_low_active;
            prev_we <= write_enable_n;
        end
    end
    task automatic t_words;
        xfer(1, 19'h00000, 16'h1234, 2'h3);
        xfer(1, 19'h7FFFF, 16'hABCD, 2'h3);
        rd(19'h00000, 2'h3, 16'h1234);
        rd(19'h7FFFF, 2'h3, 16'hABCD);
    endtask
    task automatic t_lanes;
        xfer(1, 19'h00155, 16'h5566, 2'h3);
        xfer(1, 19'h00155, 16'hAA77, 2'h1);
        xfer(1, 19'h00155, 16'h99BB, 2'h2);
        rd(19'h00155, 2'h3, 16'h9977);
        rd(19'h00155, 2'h1, 16'h0077);
        rd(19'h00155, 2'h2, 16'h9900);
    endtask
    // no lane enabled: no internal write may happen
    task automatic t_no_lane;
        xfer(1, 19'h7FFFF, 16'h0F0F, 2'h0);
        rd(19'h7FFFF, 2'h3, 16'hABCD);
    endtask
    // stalls stretch both kinds of cycle; data must still land and return
    task automatic t_freeze;
        xfer(1, 19'h2AAAA, 16'hC3E1, 2'h3, 4);
        xfer(0, 19'h2AAAA, 16'h0000, 2'h3, 3);
        check("frozen read", 19'h0C3E1, 19'(got));
    endtask
    initial
    begin
        repeat (10) @(posedge sys_clk);
        check("select low idle", 19'h1, 19'(select_low_active));
        check("select high idle", 19'h0, 19'(select_high_active));
        check("we idle", 19'h1, 19'(write_enable_n));
        check("bus oe idle", 19'h1, 19'(data_bus_oe_n));
        reset <= 0;
        t_words();
        t_lanes();
        t_no_lane();
        t_freeze();
        final_report();
    end
endmodule
`default_nettype wire
